// file: logic/btbc_core.sv
// execution of bit toggle, two conditional branches and long call
// assumes instr word is valid at phase 0 of each instruction cycle,
// and that data memory reads combinationally at the presented address
//
// Operation
// [RULE_01] toggle inverts only selected data bit
// [RULE_02] access flag 0 selects access bank
// [RULE_03] access flag 1 uses bank select
// [RULE_04] overflow branch decoded from upper byte E4
// [RULE_05] overflow branch taken only when flag set
// [RULE_06] zero branch decoded from upper byte E0
// [RULE_07] zero branch taken only when flag set
// [RULE_08] taken target is pc plus 2n
// [RULE_09] branch one cycle, two when taken
// [RULE_10] call pushes address plus four
// [RULE_11] shadow flag 1 saves three registers
// [RULE_12] shadow flag 0 leaves shadows unchanged
// [RULE_13] call target loads pc bits 20..1
// [RULE_14] call encoded in two words
// [RULE_15] call always takes two cycles
// [RULE_16] call reaches whole 2 Mbyte space
// [RULE_17] flags untouched, toggle one cycle
// [RULE_18] untaken branch advances two bytes
`timescale 1ns/100ps
`default_nettype none
module btbc_core (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic [15:0] INSTR,
  input wire logic [7:0] WORKING_REG,
  input wire logic [7:0] FLAGS_REG,
  input wire logic [3:0] BANK_SELECT_REG,
  input wire logic [7:0] DMEM_RDATA,
  output logic [btbc_pkg::DA_W-1:0] DMEM_ADDR,
  output logic [7:0] DMEM_WDATA,
  output logic DMEM_WE,
  output logic [btbc_pkg::PC_W-1:0] PC,
  output logic [1:0] Q_PHASE,
  output logic [btbc_pkg::PC_W-1:0] RETURN_STACK_TOP,
  output logic STACK_PUSH,
  output logic [7:0] WORKING_SHADOW,
  output logic [7:0] FLAGS_SHADOW,
  output logic [3:0] BANK_SELECT_SHADOW,
  output logic ILLEGAL_OP
);
  import btbc_pkg::*;

  // ----------------------------------------
  // phase counter and decode
  // ----------------------------------------
  logic [1:0] q_q;
  btbc_state_type st_q;
  logic [PC_W-1:0] pc_q;
  logic [7:0] call_lo_q;
  logic call_s_q;
  logic is_toggle, is_ovf_br, is_zero_br, is_call, is_call2, taken, acc;
  logic [2:0] bit_sel;
  logic [PC_W-1:0] br_tgt, seq_pc;
  // status bits: zero at bit 2, overflow at bit 3
  logic flag_z, flag_ov;

  assign flag_z = FLAGS_REG[2];
  assign flag_ov = FLAGS_REG[3];
  assign is_toggle = (INSTR[15:12] == TOGGLE_NIB); // RULE_01
  assign is_ovf_br = (INSTR[15:8] == OVF_BR_HI); // RULE_04
  assign is_zero_br = (INSTR[15:8] == ZERO_BR_HI); // RULE_06
  assign is_call = (INSTR[15:9] == CALL_HI7); // RULE_14
  assign is_call2 = (INSTR[15:12] == CALL2_NIB); // RULE_14
  assign taken = (is_ovf_br && flag_ov) || (is_zero_br && flag_z); // RULE_05 RULE_07
  assign bit_sel = INSTR[11:9];
  assign acc = INSTR[8];
  assign seq_pc = pc_q + PC_STEP; // RULE_18
  // pc still points at the branch itself, hence the extra step
  assign br_tgt = seq_pc + {{12{INSTR[7]}}, INSTR[7:0], 1'b0}; // RULE_08

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      q_q <= 2'h0;
    end else begin
      q_q <= q_q + 2'h1;
    end
  end

  // ----------------------------------------
  // sequencing and program counter
  // ----------------------------------------
  // flags input is only read, never written: nothing here alters status
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st_q <= ST_EXEC;
      pc_q <= '0;
      call_lo_q <= 8'h00;
      call_s_q <= 1'b0;
    end else if (q_q == Q_LAST) begin
      unique case (st_q)
        ST_EXEC: begin
          if (taken) begin
            pc_q <= br_tgt; // RULE_08
            st_q <= ST_FLUSH; // RULE_09
          end else if (is_call) begin
            call_lo_q <= INSTR[7:0];
            call_s_q <= INSTR[8];
            pc_q <= seq_pc;
            st_q <= ST_CALL2; // RULE_15
          end else begin
            pc_q <= seq_pc; // RULE_09 RULE_17 RULE_18
          end
        end
        ST_FLUSH: begin
          pc_q <= seq_pc; // RULE_09
          st_q <= ST_EXEC;
        end
        ST_CALL2: begin
          // second word always consumed as a no-op cycle
          pc_q <= {INSTR[11:0], call_lo_q, 1'b0}; // RULE_13 RULE_16
          st_q <= ST_EXEC; // RULE_15
        end
        default: st_q <= ST_EXEC;
      endcase
    end
  end

  // ----------------------------------------
  // return stack push and shadow save
  // ----------------------------------------
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RETURN_STACK_TOP <= '0;
      STACK_PUSH <= 1'b0;
      WORKING_SHADOW <= 8'h00;
      FLAGS_SHADOW <= 8'h00;
      BANK_SELECT_SHADOW <= 4'h0;
    end else begin
      STACK_PUSH <= 1'b0;
      if (q_q == Q_LAST && st_q == ST_EXEC && !taken && is_call) begin
        RETURN_STACK_TOP <= pc_q + CALL_RET_OFS; // RULE_10
        STACK_PUSH <= 1'b1; // RULE_10
        if (INSTR[8]) begin
          WORKING_SHADOW <= WORKING_REG; // RULE_11
          FLAGS_SHADOW <= FLAGS_REG; // RULE_11
          BANK_SELECT_SHADOW <= BANK_SELECT_REG; // RULE_11
        end // otherwise shadows hold: RULE_12
      end
    end
  end

  // ----------------------------------------
  // bit toggle data path
  // ----------------------------------------
  logic tog_act;
  logic [DA_W-1:0] addr_d;
  assign tog_act = (st_q == ST_EXEC) && is_toggle;
  always_comb begin
    if (!acc) begin
      // low half of access bank is ram, high half the sfr page
      addr_d = {(INSTR[7:0] < ACCESS_SPLIT) ? ACCESS_BANK
                : ACCESS_HIGH_BANK, INSTR[7:0]}; // RULE_02
    end else begin
      addr_d = {BANK_SELECT_REG, INSTR[7:0]}; // RULE_03
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      DMEM_ADDR <= '0;
      DMEM_WDATA <= 8'h00;
      DMEM_WE <= 1'b0;
    end else begin
      DMEM_WE <= 1'b0;
      DMEM_ADDR <= addr_d;
      if (tog_act && q_q == 2'h2) begin
        DMEM_WDATA <= DMEM_RDATA ^ (8'h01 << bit_sel); // RULE_01
        DMEM_WE <= 1'b1; // RULE_17
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ILLEGAL_OP <= 1'b0;
    end else begin
      ILLEGAL_OP <= (st_q == ST_CALL2) && !is_call2;
    end
  end

  assign PC = pc_q;
  assign Q_PHASE = q_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // ----------------------------------------
  // toggle checks
  // ----------------------------------------
  // read data is taken one edge before the write strobe shows
  chk_toggle_bit: assert property ( // RULE_01
    @(posedge REF_CLK) disable iff (!RESETN)
    DMEM_WE |-> $countones(DMEM_WDATA ^ $past(DMEM_RDATA)) == 1)
    else $error("toggle changed other than one bit");

  // one write per toggle, in the last phase of its own cycle
  chk_toggle_once: assert property ( // RULE_17
    @(posedge REF_CLK) disable iff (!RESETN)
    DMEM_WE |-> q_q == Q_LAST && st_q == ST_EXEC)
    else $error("toggle write outside its cycle");

  chk_access_bank: assert property ( // RULE_02
    @(posedge REF_CLK) disable iff (!RESETN)
    (!acc && INSTR[7] == 1'b0) |=> DMEM_ADDR[11:8] == ACCESS_BANK)
    else $error("access bank not used");

  chk_bank_sel: assert property ( // RULE_03
    @(posedge REF_CLK) disable iff (!RESETN)
    acc |=> DMEM_ADDR[11:8] == $past(BANK_SELECT_REG))
    else $error("bank select ignored");

  // ----------------------------------------
  // branch checks
  // ----------------------------------------
  // opcode written out here so a wrong package value shows up
  chk_ovf_decode: assert property ( // RULE_04
    @(posedge REF_CLK) disable iff (!RESETN)
    (INSTR[15:8] == 8'hE4) |-> is_ovf_br && !is_zero_br && !is_toggle)
    else $error("overflow branch not decoded");

  chk_zero_decode: assert property ( // RULE_06
    @(posedge REF_CLK) disable iff (!RESETN)
    (INSTR[15:8] == 8'hE0) |-> is_zero_br && !is_ovf_br && !is_call)
    else $error("zero branch not decoded");

  chk_ovf_taken: assert property ( // RULE_05
    @(posedge REF_CLK) disable iff (!RESETN)
    (q_q == Q_LAST && st_q == ST_EXEC && is_ovf_br && flag_ov)
    |=> st_q == ST_FLUSH)
    else $error("overflow branch not taken");

  chk_zero_taken: assert property ( // RULE_07
    @(posedge REF_CLK) disable iff (!RESETN)
    (q_q == Q_LAST && st_q == ST_EXEC && is_zero_br && flag_z)
    |=> st_q == ST_FLUSH)
    else $error("zero branch not taken");

  // offset rebuilt from the word, not from the adder above
  chk_branch_ofs: assert property ( // RULE_08
    @(posedge REF_CLK) disable iff (!RESETN)
    (q_q == Q_LAST && st_q == ST_EXEC && taken)
    |=> pc_q == $past(pc_q) + PC_STEP
    + {{12{$past(INSTR[7])}}, $past(INSTR[7:0]), 1'b0})
    else $error("branch target wrong");

  chk_branch_seq: assert property ( // RULE_18
    @(posedge REF_CLK) disable iff (!RESETN)
    (q_q == Q_LAST && st_q == ST_EXEC && (is_zero_br || is_ovf_br)
    && !taken) |=> pc_q == $past(pc_q) + PC_STEP && st_q == ST_EXEC)
    else $error("untaken branch did not step");

  // four clocks make one instruction cycle of no-operation
  chk_flush_len: assert property ( // RULE_09
    @(posedge REF_CLK) disable iff (!RESETN)
    $rose(st_q == ST_FLUSH) |-> (st_q == ST_FLUSH)[*4] ##1 st_q == ST_EXEC)
    else $error("flush cycle length wrong");

  // ----------------------------------------
  // call checks
  // ----------------------------------------
  chk_call_push: assert property ( // RULE_10
    @(posedge REF_CLK) disable iff (!RESETN)
    STACK_PUSH |-> RETURN_STACK_TOP == $past(pc_q) + CALL_RET_OFS
    && st_q == ST_CALL2)
    else $error("bad return address");

  // shadows are written on the edge just before the push shows
  chk_shadow_save: assert property ( // RULE_11
    @(posedge REF_CLK) disable iff (!RESETN)
    (STACK_PUSH && call_s_q) |-> WORKING_SHADOW == $past(WORKING_REG)
    && FLAGS_SHADOW == $past(FLAGS_REG)
    && BANK_SELECT_SHADOW == $past(BANK_SELECT_REG))
    else $error("shadow not saved");

  chk_shadow_hold: assert property ( // RULE_12
    @(posedge REF_CLK) disable iff (!RESETN)
    (STACK_PUSH && !call_s_q) |-> $stable(WORKING_SHADOW)
    && $stable(FLAGS_SHADOW) && $stable(BANK_SELECT_SHADOW))
    else $error("shadow changed without flag");

  chk_call_target: assert property ( // RULE_13
    @(posedge REF_CLK) disable iff (!RESETN)
    (q_q == Q_LAST && st_q == ST_CALL2) |=> st_q == ST_EXEC
    && pc_q == {$past(INSTR[11:0]), call_lo_q, 1'b0})
    else $error("call target wrong");

  // a bad second word is only flagged; the core above decides
  chk_call_word2: assert property ( // RULE_14
    @(posedge REF_CLK) disable iff (!RESETN)
    (q_q == Q_LAST && st_q == ST_CALL2)
    |=> ILLEGAL_OP == ($past(INSTR[15:12]) != CALL2_NIB))
    else $error("second call word not checked");

  chk_call_len: assert property ( // RULE_15
    @(posedge REF_CLK) disable iff (!RESETN)
    $rose(st_q == ST_CALL2) |-> (st_q == ST_CALL2)[*4] ##1 st_q == ST_EXEC)
    else $error("call length wrong");

  chk_call_reach: assert property ( // RULE_16
    @(posedge REF_CLK) disable iff (!RESETN)
    (q_q == Q_LAST && st_q == ST_CALL2)
    |=> pc_q[20:13] == $past(INSTR[11:4]))
    else $error("call target upper bits lost");
endmodule
`default_nettype wire

// file: logic/btbc_pkg.sv
// package for the toggle/branch/call execution block
// assumes a 21-bit byte program counter and 12-bit data addresses
package btbc_pkg;
  localparam int PC_W = 21;
  localparam int DA_W = 12;
  localparam logic [3:0] TOGGLE_NIB = 4'h7;
  localparam logic [7:0] OVF_BR_HI = 8'hE4;
  localparam logic [7:0] ZERO_BR_HI = 8'hE0;
  localparam logic [6:0] CALL_HI7 = 7'h76;
  localparam logic [3:0] CALL2_NIB = 4'hF;
  localparam logic [3:0] ACCESS_BANK = 4'h0;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] CALL_RET_OFS = 21'h000004;
  localparam logic [1:0] Q_LAST = 2'h3;
  typedef enum logic [1:0] {
    ST_EXEC  = 2'b00,
    ST_FLUSH = 2'b01,
    ST_CALL2 = 2'b10
  } btbc_state_type;
endpackage

// file: tb/btbc_core_test.sv
// self-checking bench for the toggle/branch/call block
// assumes btbc_pkg and btbc_core are compiled first
`timescale 1ns/100ps
`default_nettype none
module btbc_core_test;
  import btbc_pkg::*;
  logic ref_clk, resetn, we, push, illegal;
  logic [15:0] instr;
  logic [7:0] working, flags, rdata, wdata, wsh, fs, we_data;
  logic [3:0] bank, bs;
  logic [DA_W-1:0] daddr, we_addr;
  logic [PC_W-1:0] pc, top, push_val, exp_pc;
  logic [1:0] qph;
  int mismatches, checks_done, we_cnt, push_cnt;
  // --------------------------------
  // clock, dut, data memory stand-in
  // --------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // read data differs per byte so a wrong address shows up
  assign rdata = daddr[7:0] ^ 8'hA5;
  btbc_core i_dut (.REF_CLK(ref_clk), .RESETN(resetn), .INSTR(instr),
    .WORKING_REG(working), .FLAGS_REG(flags), .BANK_SELECT_REG(bank),
    .DMEM_RDATA(rdata), .DMEM_ADDR(daddr), .DMEM_WDATA(wdata),
    .DMEM_WE(we), .PC(pc), .Q_PHASE(qph), .RETURN_STACK_TOP(top),
    .STACK_PUSH(push), .WORKING_SHADOW(wsh), .FLAGS_SHADOW(fs),
    .BANK_SELECT_SHADOW(bs), .ILLEGAL_OP(illegal));
  always @(posedge ref_clk) begin
    if (we === 1'b1) begin
      we_cnt++;
      we_addr = daddr;
      we_data = wdata;
    end
    if (push === 1'b1) begin
      push_cnt++;
      push_val = top;
    end
  end
  // --------------------------------
  // shared tasks
  // --------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one instruction cycle is four clocks, entered at a phase 0 negedge
  task automatic issue(input logic [15:0] w);
    check(qph, 2'h0);
    instr = w;
    repeat (4) @(negedge ref_clk);
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic toggle(input logic [2:0] b, input logic a,
                        input logic [7:0] f);
    logic [DA_W-1:0] ea;
    int c;
    c = we_cnt;
    ea = a ? {bank, f} : (f < ACCESS_SPLIT ? {ACCESS_BANK, f}
                                           : {ACCESS_HIGH_BANK, f});
    issue({TOGGLE_NIB, b, a, f});
    exp_pc = exp_pc + PC_STEP;
    check(24'(we_cnt - c), 24'h1);
    check(we_addr, ea);
    check(we_data, (ea[7:0] ^ 8'hA5) ^ (8'h01 << b));
    check(pc, exp_pc);
  endtask
  task automatic branch(input logic [7:0] hi, input logic take,
                        input logic [7:0] n);
    int c;
    c = we_cnt;
    // the other flag is set opposite, catching a swapped decode
    flags = (take ^ (hi == ZERO_BR_HI)) ? 8'h08 : 8'h04;
    issue({hi, n});
    exp_pc = exp_pc + PC_STEP + (take ? {{12{n[7]}}, n, 1'b0} : 21'h0);
    check(pc, exp_pc);
    if (take) begin
      issue({TOGGLE_NIB, 4'h0, 8'h10});
      exp_pc = exp_pc + PC_STEP;
      check(pc, exp_pc);
    end
    check(24'(we_cnt - c), 24'h0);
  endtask
  task automatic call(input logic s, input logic [19:0] k);
    int c;
    logic [7:0] w0, f0;
    logic [3:0] b0;
    c = push_cnt;
    w0 = wsh;
    f0 = fs;
    b0 = bs;
    issue({CALL_HI7, s, k[7:0]});
    issue({CALL2_NIB, k[19:8]});
    check(24'(push_cnt - c), 24'h1);
    check(push_val, PC_W'(exp_pc + CALL_RET_OFS));
    check(wsh, s ? working : w0);
    check(fs, s ? flags : f0);
    check(bs, s ? bank : b0);
    exp_pc = {k, 1'b0};
    check(pc, exp_pc);
    check(illegal, 1'b0);
  endtask
  // --------------------------------
  // main sequence and watchdog
  // --------------------------------
  initial begin
    resetn = 1'b0;
    instr = 16'h0000;
    working = 8'h5A;
    flags = 8'hC3;
    bank = 4'h6;
    exp_pc = '0;
    repeat (2) @(negedge ref_clk);
    // phase 0 stands from release, so the first word goes in now
    resetn = 1'b1;
    for (int i = 0; i < 8 && qph !== 2'h0; i++) @(negedge ref_clk);
    toggle(3'h4, 1'b0, 8'h45);
    toggle(3'h7, 1'b0, 8'h9C);
    toggle(3'h0, 1'b1, 8'h21);
    call(1'b1, 20'hFFFFF);
    working = 8'h11;
    flags = 8'h22;
    bank = 4'h3;
    call(1'b0, 20'h40000);
    branch(OVF_BR_HI, 1'b1, 8'h80);
    branch(OVF_BR_HI, 1'b0, 8'h7F);
    branch(ZERO_BR_HI, 1'b1, 8'h7F);
    branch(ZERO_BR_HI, 1'b0, 8'h80);
    results();
  end
  initial begin
    #20000;
    mismatches++;
    results();
  end
endmodule
`default_nettype wire
